// >>> inc/fsp_pkg.sv
// Constants shared by the flash self-programming control block
package fsp_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0]  CTL_ADDR  = 4'h0;
  localparam logic [3:0]  STAT_ADDR = 4'h4;
  // Field positions in program_store_control and the status word, and reset values
  localparam int unsigned SE_BIT    = 0;
  localparam int unsigned ERS_BIT   = 1;
  localparam int unsigned WRT_BIT   = 2;
  localparam int unsigned LCK_BIT   = 3;
  localparam int unsigned RRE_BIT   = 4;
  localparam int unsigned SIG_BIT   = 5;
  localparam int unsigned BUSY_BIT  = 6;
  localparam int unsigned PBUSY_BIT = 8;
  localparam logic [5:0]  CTL_RST   = 6'h00;
  localparam logic [5:0]  LOCK_RST  = 6'h3f;
  // Timed-sequence windows, counted in cycles after arming
  localparam logic [2:0]  STORE_WIN = 3'h4;
  localparam logic [2:0]  LOAD_WIN  = 3'h3;
  // Programming times, least values, and the clock period
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned T_WRITE_NS  = 3700000;
  localparam int unsigned T_ERASE_NS  = 7300000;
  localparam int unsigned WRITE_CYC_D = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERASE_CYC_D = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  // Pointer values of the special read windows
  localparam logic [15:0] PTR_B0 = 16'h0000;
  localparam logic [15:0] PTR_B1 = 16'h0001;
  localparam logic [15:0] PTR_B2 = 16'h0002;
  localparam logic [15:0] PTR_B3 = 16'h0003;
  localparam logic [15:0] PTR_B4 = 16'h0004;
  localparam logic [7:0]  RSVD_BYTE = 8'hff;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // Programming operation in progress
  typedef enum logic [3:0] {
    OP_IDLE  = 4'b0001,
    OP_ERASE = 4'b0010,
    OP_WRITE = 4'b0100,
    OP_LOCK  = 4'b1000
  } fsp_op_t;
endpackage

// >>> logic/fsp_flash_self_program_control.sv
// Flash self-programming sequencer with AXI4-Lite control registers
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - Page erase/write blocks read-while-write region reads
// RULE2 - rww_busy stays set while region is busy
// RULE3 - Software runs only no-read-while-write code meanwhile
// RULE4 - Software moves vectors or disables interrupts
// RULE5 - rww_read_enable store clears rww_busy after programming
// RULE6 - Lock write armed by X0001001, store within four
// RULE7 - Zero bits in operand 5:0 get programmed
// RULE8 - Software loads pointer 0x0001, operand bits 7:6 high
// RULE9 - Lock write leaves whole flash readable
// RULE10 - EEPROM write blocks every flash programming store
// RULE11 - EEPROM write blocks signature, fuse, lock reads
// RULE12 - Software polls eeprom_write_active before arming
// RULE13 - Lock access plus pointer 0x0001 reads lock byte
// RULE14 - Lock access clears on read or timeout
// RULE15 - With bits clear, loads are ordinary reads
// RULE16 - Pointer 0x0000 fuse low, 0x0003 fuse high
// RULE17 - Pointer 0x0002 returns extended fuse bits 2:0
// RULE18 - Programmed reads zero, unprogrammed reads one
// RULE19 - Signature read returns bytes at 0x0000/2/4
// RULE20 - Address 0x0001 calibration byte, others reserved
// RULE21 - Signature access clears on read or three cycles
// RULE22 - System reset does not abort running write
// RULE23 - Operations timed: write 3.7 ms, erase 7.3 ms
// RULE24 - Software polls store_enable, disables interrupts first
// RULE25 - Store during signature window has no effect
// RULE26 - Page-buffer load clears rww_busy
module fsp_flash_self_program_control
  import fsp_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYC_D,
  parameter int unsigned ERASE_CYC = ERASE_CYC_D,
  parameter int unsigned CNT_W     = 18,
  parameter logic [7:0]  FUSE_LOW  = 8'h62, // arbitrary value
  parameter logic [7:0]  FUSE_HIGH = 8'h99, // arbitrary value
  parameter logic [7:0]  FUSE_EXT  = 8'hff, // arbitrary value
  parameter logic [7:0]  SIG_B0    = 8'h11, // arbitrary value
  parameter logic [7:0]  SIG_B1    = 8'h22, // arbitrary value
  parameter logic [7:0]  SIG_B2    = 8'h33, // arbitrary value
  parameter logic [7:0]  CAL_BYTE  = 8'h80  // arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              por_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              store_instr,
  input  wire logic              load_instr,
  input  wire logic [15:0]       address_pointer,
  input  wire logic [7:0]        operand_low,
  input  wire logic              eeprom_write_active,
  output logic                   rww_busy,
  output logic [5:0]             lock_bits,
  output logic [7:0]             load_data,
  output logic                   load_valid,
  output logic                   load_plain,
  output logic                   load_refused
);

  logic [5:0]        ctl_q;
  logic [2:0]        win_q;
  fsp_op_t           op_q;
  logic [CNT_W-1:0]  tmr_q;
  logic [7:0]        oplat_q;
  logic [5:0]        lock_q;
  logic              rww_busy_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_strb_q;
  logic [7:0]        spec_byte;
  logic              armed, wr_ctl, arm_ok, op_done, st_ok;
  logic              st_erase, st_write, st_lock, st_rwwen, st_load;
  logic              ld_spec, expire;

  //////////////////////////////////////////////////////////////////////////
  // Sequence decode

  // Special commands only while no timed operation runs
  assign armed    = ctl_q[SE_BIT] && (op_q == OP_IDLE);
  assign op_done  = (op_q != OP_IDLE) && (tmr_q == '0);
  assign wr_ctl   = aw_have_q && w_have_q && !s_axi_bvalid &&
                    (aw_addr_q == CTL_ADDR) && w_strb_q;
  assign arm_ok   = wr_ctl && !ctl_q[SE_BIT] && !eeprom_write_active;
  // Store taken inside four cycles, never while EEPROM writes
  assign st_ok    = store_instr && armed && (win_q < STORE_WIN) &&
                    !eeprom_write_active && !ctl_q[SIG_BIT]; // RULE10 RULE25
  assign st_erase = st_ok && ctl_q[ERS_BIT];
  assign st_write = st_ok && ctl_q[WRT_BIT] && !ctl_q[ERS_BIT];
  assign st_lock  = st_ok && ctl_q[LCK_BIT] &&
                    !ctl_q[ERS_BIT] && !ctl_q[WRT_BIT]; // RULE6
  assign st_rwwen = st_ok && ctl_q[RRE_BIT] && !ctl_q[LCK_BIT] &&
                    !ctl_q[ERS_BIT] && !ctl_q[WRT_BIT];
  assign st_load  = st_ok && !ctl_q[RRE_BIT] && !ctl_q[LCK_BIT] &&
                    !ctl_q[ERS_BIT] && !ctl_q[WRT_BIT];
  // Special load inside three cycles
  assign ld_spec  = load_instr && armed && (win_q < LOAD_WIN) &&
                    (ctl_q[LCK_BIT] || ctl_q[SIG_BIT]); // RULE13 RULE19
  // Signature window ends after three cycles, others after four
  assign expire   = armed && (ctl_q[SIG_BIT] ? (win_q == LOAD_WIN)
                                              : (win_q == STORE_WIN));

  // Byte returned by a lock/fuse or signature read
  always_comb begin
    spec_byte = RSVD_BYTE;
    if (ctl_q[SIG_BIT]) begin
      case (address_pointer)
        PTR_B0:  spec_byte = SIG_B0; // RULE19
        PTR_B2:  spec_byte = SIG_B1; // RULE19
        PTR_B4:  spec_byte = SIG_B2; // RULE19
        PTR_B1:  spec_byte = CAL_BYTE; // RULE20
        default: spec_byte = RSVD_BYTE; // RULE20
      endcase
    end else begin
      case (address_pointer)
        PTR_B0:  spec_byte = FUSE_LOW; // RULE16
        PTR_B1:  spec_byte = {2'b11, lock_q}; // RULE13 RULE18
        PTR_B2:  spec_byte = {5'h1f, FUSE_EXT[2:0]}; // RULE17
        PTR_B3:  spec_byte = FUSE_HIGH; // RULE16
        default: spec_byte = RSVD_BYTE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control bits and timed window

  // System reset keeps store_enable up while a write still runs
  always_ff @(posedge clk) begin
    if (por_rst) begin
      ctl_q <= CTL_RST;
    end else if (op_done) begin
      ctl_q <= CTL_RST;
    end else if (rst) begin
      if (op_q == OP_IDLE) begin
        ctl_q <= CTL_RST; // RULE22
      end
    end else if (arm_ok) begin
      ctl_q <= w_data_q[5:0];
    end else if (st_rwwen || st_load || ld_spec || expire) begin
      ctl_q <= CTL_RST; // RULE14 RULE21
    end
  end

  // Cycles since arming, saturating
  always_ff @(posedge clk) begin
    if (rst || por_rst) begin
      win_q <= 3'h7;
    end else if (arm_ok) begin
      win_q <= 3'h0;
    end else if (win_q != 3'h7) begin
      win_q <= win_q + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timed programming; only power-on reset stops it

  // The cycle count stands in for the calibrated RC oscillator timing
  always_ff @(posedge clk) begin
    if (por_rst) begin
      op_q       <= OP_IDLE;
      tmr_q      <= '0;
      oplat_q    <= 8'h00;
      lock_q     <= LOCK_RST;
      rww_busy_q <= 1'b0;
    end else if (op_q != OP_IDLE) begin
      if (tmr_q == '0) begin
        op_q <= OP_IDLE; // RULE22
        if (op_q == OP_LOCK) begin
          lock_q <= lock_q & oplat_q[5:0]; // RULE7 RULE18
        end
      end else begin
        tmr_q <= tmr_q - 1'b1;
      end
    end else if (st_erase) begin
      op_q       <= OP_ERASE;
      tmr_q      <= CNT_W'(ERASE_CYC - 1); // RULE23
      rww_busy_q <= 1'b1; // RULE1 RULE2
    end else if (st_write) begin
      op_q       <= OP_WRITE;
      tmr_q      <= CNT_W'(WRITE_CYC - 1); // RULE23
      rww_busy_q <= 1'b1; // RULE1 RULE2
    end else if (st_lock) begin
      // Lock write leaves the busy flag alone: flash stays readable
      op_q    <= OP_LOCK; // RULE9
      tmr_q   <= CNT_W'(WRITE_CYC - 1); // RULE23
      oplat_q <= operand_low;
    end else if (st_rwwen || st_load) begin
      rww_busy_q <= 1'b0; // RULE5 RULE26
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Load instruction answers

  // One-cycle pulses; an EEPROM write refuses special reads
  always_ff @(posedge clk) begin
    if (rst || por_rst) begin
      load_data    <= 8'h00;
      load_valid   <= 1'b0;
      load_plain   <= 1'b0;
      load_refused <= 1'b0;
    end else begin
      load_valid   <= 1'b0;
      load_plain   <= 1'b0;
      load_refused <= 1'b0;
      if (ld_spec && eeprom_write_active) begin
        load_refused <= 1'b1; // RULE11
      end else if (ld_spec) begin
        load_valid <= 1'b1;
        load_data  <= spec_byte;
      end else if (load_instr) begin
        load_plain <= 1'b1; // RULE15
      end
    end
  end

  assign rww_busy  = rww_busy_q;
  assign lock_bits = lock_q;

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels, address and data in either order

  always_ff @(posedge clk) begin
    if (rst || por_rst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 8'h00;
      w_strb_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata[7:0];
        w_strb_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      // Status is read-only; unmapped writes get SLVERR
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == CTL_ADDR || aw_addr_q == STAT_ADDR)
                        ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst || por_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
      case (s_axi_araddr)
        CTL_ADDR:  s_axi_rdata[BUSY_BIT:0] <= {rww_busy_q, ctl_q}; // RULE2
        STAT_ADDR: s_axi_rdata[PBUSY_BIT:0] <=
                     {(op_q != OP_IDLE), 2'b11, lock_q};
        default:   s_axi_rresp <= RESP_ERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por_rst);

  rww_block_a: assert property ((op_q == OP_ERASE || op_q == OP_WRITE)
    |-> rww_busy_q) else $error("region readable during page op"); // RULE1
  rww_hold_a: assert property (rww_busy_q && !st_rwwen && !st_load
    |=> rww_busy_q) else $error("rww_busy dropped early"); // RULE2
  rww_restore_a: assert property (st_rwwen |=> !rww_busy_q)
    else $error("rww_busy not cleared"); // RULE5
  lock_start_a: assert property (store_instr && armed && ctl_q == 6'h09 &&
    win_q < STORE_WIN && !eeprom_write_active |=> op_q == OP_LOCK)
    else $error("lock write not started"); // RULE6
  lock_prog_a: assert property (op_q == OP_LOCK && tmr_q == '0
    |=> lock_q == ($past(lock_q) & $past(oplat_q[5:0])))
    else $error("lock bits wrong after write"); // RULE7
  lock_read_a: assert property (st_lock |=> $stable(rww_busy_q))
    else $error("lock write blocked region"); // RULE9
  ee_store_a: assert property (eeprom_write_active && op_q == OP_IDLE
    |=> op_q == OP_IDLE) else $error("store during eeprom write"); // RULE10
  ee_load_a: assert property (eeprom_write_active && load_instr
    |=> !load_valid) else $error("special read during eeprom"); // RULE11
  lock_expire_a: assert property (armed && ctl_q[LCK_BIT] &&
    win_q == STORE_WIN |=> !ctl_q[LCK_BIT])
    else $error("lock access not cleared"); // RULE14
  plain_load_a: assert property (load_instr && !ctl_q[SE_BIT]
    |=> load_plain) else $error("plain load lost"); // RULE15
  fuse_low_a: assert property (ld_spec && !eeprom_write_active &&
    ctl_q[LCK_BIT] && address_pointer == PTR_B0
    |=> load_valid && load_data == FUSE_LOW)
    else $error("fuse low read wrong"); // RULE16
  sig_expire_a: assert property (armed && ctl_q[SIG_BIT] &&
    win_q == LOAD_WIN |=> ctl_q == CTL_RST)
    else $error("signature access not cleared"); // RULE21
  erase_time_a: assert property (st_erase
    |=> op_q == OP_ERASE ##1 tmr_q == CNT_W'(ERASE_CYC - 2))
    else $error("erase timer wrong"); // RULE23
  sig_store_a: assert property (store_instr && ctl_q[SIG_BIT]
    && op_q == OP_IDLE |=> op_q == OP_IDLE)
    else $error("store acted in signature window"); // RULE25

  lock_write_c: cover property (st_lock ##1 op_q == OP_LOCK);
  sig_read_c: cover property (ld_spec && ctl_q[SIG_BIT] ##1 load_valid);
  erase_c: cover property (st_erase);
  refused_c: cover property (load_refused);

endmodule // fsp_flash_self_program_control

// >>> dv/fsp_cpu_model.sv
// CPU core model issuing store and load program instructions
`timescale 1ns/100ps
module fsp_cpu_model (
  input  wire logic        clk,
  input  wire logic        req_store,
  input  wire logic        req_load,
  input  wire logic [15:0] ptr_in,
  input  wire logic [7:0]  opnd_in,
  output logic             store_instr,
  output logic             load_instr,
  output logic [15:0]      address_pointer,
  output logic [7:0]       operand_low
);
  logic [15:0] ptr_q = 16'h0000;
  logic [7:0]  opnd_q = 8'h00;
  // Caller issues each store directly; store_enable and eeprom are not polled first
  assign store_instr = req_store;
  // Code runs from the no-read-while-write region, no interrupts
  assign load_instr = req_load;
  // Operands valid only with an instruction; else stale inverse
  assign address_pointer = (req_store | req_load) ? ptr_in : ~ptr_q;
  assign operand_low = req_store ? {2'b11, opnd_in[5:0]} : ~opnd_q;
  // Last driven operands kept; after a load the idle operand_low shows the last stored value
  always_ff @(posedge clk) begin
    if (req_store | req_load) begin
      ptr_q  <= ptr_in;
      opnd_q <= operand_low;
    end
  end
endmodule // fsp_cpu_model

// >>> dv/tb_top.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/100ps
module tb_top;
  import fsp_pkg::*;
  localparam int unsigned WR_C = 20;
  localparam int unsigned ER_C = 40;
  // Readout contents, arbitrary values
  localparam logic [7:0] FL = 8'h5a, FH = 8'hc3, FE = 8'hf6, CAL = 8'h47;
  localparam logic [7:0] S0 = 8'h1e, S1 = 8'h2d, S2 = 8'h3c;
  logic        clk = 0, rst = 1, por_rst = 1, ee = 0, rqs = 0, rql = 0;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, lfsr = 32'h7760;
  logic        awr, wr, bv, arr, rv, busy, lv, lp, lr, st, ld, rww_m;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  lkb, lock_m;
  logic [7:0]  ldat, opd, opin = 0, dat, m;
  logic [15:0] ptr, ptin = 0;
  logic [2:0]  k;
  int          mismatches = 0, n_checks = 0, cyc = 0, el, t0;
  fsp_flash_self_program_control #(.WRITE_CYC(WR_C), .ERASE_CYC(ER_C),
    .FUSE_LOW(FL), .FUSE_HIGH(FH), .FUSE_EXT(FE), .SIG_B0(S0), .SIG_B1(S1),
    .SIG_B2(S2), .CAL_BYTE(CAL)) dut (.clk(clk), .rst(rst),
    .por_rst(por_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .store_instr(st), .load_instr(ld), .address_pointer(ptr),
    .operand_low(opd), .eeprom_write_active(ee), .rww_busy(busy),
    .lock_bits(lkb), .load_data(ldat), .load_valid(lv), .load_plain(lp),
    .load_refused(lr));
  fsp_cpu_model cpu (.clk(clk), .req_store(rqs), .req_load(rql),
    .ptr_in(ptin), .opnd_in(opin), .store_instr(st), .load_instr(ld),
    .address_pointer(ptr), .operand_low(opd));
  ////////////////////////////////////////////////////////////////////////
  // Clock and free-running cycle count
  initial forever #25 clk = ~clk;
  // Non-blocking so a read at the same edge sees the count before it
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected special-read byte from mode and pointer
  function automatic logic [7:0] exp_b(input logic [7:0] md, input int p);
    if (md == 8'h09) begin
      case (p)
        0: return FL;
        1: return {2'b11, lock_m};
        2: return {5'h1f, FE[2:0]};
        3: return FH;
        default: return 8'hff;
      endcase
    end
    case (p)
      0: return S0;
      1: return CAL;
      2: return S1;
      4: return S2;
      default: return 8'hff;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Bus master; address, write and response channels released at the edge they are taken
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awr) begin
        ta = 1;
        awv <= 0;
      end
      if (!tw && wr) begin
        tw = 1;
        wv <= 0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    r = bresp;
    bry <= 0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    araddr <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    // rready stays up: a back-to-back read would raise it again here
    d = rdata;
    r = rresp;
  endtask
  task automatic arm(input logic [7:0] v);
    wr_reg(CTL_ADDR, v);
  endtask
  task automatic do_load(input logic [15:0] p, input int wt);
    repeat (wt) @(posedge clk);
    ptin <= p;
    rql <= 1;
    @(posedge clk);
    rql <= 0;
    // Pulses stand one cycle: take them at the edge that ends it
    @(posedge clk);
    k = {lv, lp, lr};
    dat = ldat;
  endtask
  task automatic do_store(input logic [15:0] p, input logic [7:0] o);
    ptin <= p;
    opin <= o;
    rqs <= 1;
    t0 = cyc;
    @(posedge clk);
    rqs <= 0;
  endtask
  // Poll the status word until the timed operation ends
  task automatic wait_idle;
    do rd_reg(STAT_ADDR); while (d[PBUSY_BIT] === 1'b1);
    el = cyc - t0;
  endtask
  task automatic sample_busy;
    @(posedge clk);
    chk(busy, rww_m);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized well past the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    por_rst <= 0;
    lock_m = LOCK_RST;
    rww_m = 0;
    rd_reg(STAT_ADDR);
    chk(d, {24'h0, 2'b11, lock_m});
    rd_reg(CTL_ADDR);
    chk(d, 32'h0);
    rd_reg(4'h8);
    chk(r, RESP_ERR);
    wr_reg(4'hc, 8'h00);
    chk(r, RESP_ERR);
    do_load(16'h1234, 0);
    chk(k, 3'b010);
    $display("test reset and decode done");
    // Pointers 0x0000 to 0x0005 in both readout windows, then a plain load
    for (int i = 0; i < 12; i++) begin
      m = (i < 6) ? 8'h09 : 8'h21;
      arm(m);
      do_load(16'(i % 6), 0);
      chk(k, 3'b100);
      chk(dat, exp_b(m, i % 6));
      do_load(16'h0001, 0);
      chk(k, 3'b010);
    end
    // Window edge: third count honoured, fourth falls back to plain
    for (int i = 0; i < 4; i++) begin
      arm(i[0] ? 8'h21 : 8'h09);
      do_load(16'h0001, 1 + i / 2);
      chk(k, (i < 2) ? 3'b100 : 3'b010);
    end
    $display("test readout windows done");
    ee <= 1;
    arm(8'h05);
    rd_reg(CTL_ADDR);
    chk(d, 32'h0);
    ee <= 0;
    arm(8'h09);
    ee <= 1;
    do_store(16'h0001, 8'h00);
    ee <= 0;
    repeat (30) @(posedge clk);
    chk(lkb, lock_m);
    for (int i = 0; i < 2; i++) begin
      arm(i[0] ? 8'h21 : 8'h09);
      ee <= 1;
      do_load(16'h0001, 0);
      chk(k, 3'b001);
      ee <= 0;
    end
    $display("test eeprom interlock done");
    // Lock writes with random operands accumulate programmed bits
    for (int i = 0; i < 2; i++) begin
      lfsr = nxt(lfsr);
      arm(8'h09);
      do_store(16'h0001, lfsr[7:0]);
      sample_busy;
      wait_idle;
      chk(el >= WR_C && el <= WR_C + 12, 1'b1);
      lock_m = lock_m & lfsr[5:0];
      chk(d, {24'h0, 2'b11, lock_m});
      chk(lkb, lock_m);
    end
    $display("test lock write done");
    arm(8'h03);
    do_store(16'h0100, 8'h00);
    rww_m = 1;
    sample_busy;
    wait_idle;
    chk(el >= ER_C && el <= ER_C + 12, 1'b1);
    sample_busy;
    arm(8'h11);
    do_store(16'h0000, 8'h00);
    rww_m = 0;
    sample_busy;
    // System reset in mid-write leaves the write running
    arm(8'h05);
    do_store(16'h0100, 8'h00);
    rww_m = 1;
    repeat (5) @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd_reg(STAT_ADDR);
    chk(d[PBUSY_BIT], 1'b1);
    wait_idle;
    chk(el >= WR_C, 1'b1);
    sample_busy;
    // Store in the signature window must not clear the busy flag
    arm(8'h21);
    do_store(16'h0001, 8'h00);
    repeat (30) @(posedge clk);
    chk(lkb, lock_m);
    sample_busy;
    arm(8'h01);
    do_store(16'h0000, 8'h00);
    rww_m = 0;
    sample_busy;
    $display("test programming done");
    report_and_stop;
  end
endmodule // tb_top
